// File: alarm_pkg.sv
// Package: register map, field layout and constants of the alarm unit.
package alarm_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_SEC   = 8'h00; // Seconds count.
  localparam logic [7:0] ADDR_MIN   = 8'h01; // Minutes count.
  localparam logic [7:0] ADDR_HOUR  = 8'h02; // Hours count.
  localparam logic [7:0] ADDR_WDAY  = 8'h03; // Weekday count.
  localparam logic [7:0] ADDR_DATE  = 8'h04; // Date count.
  localparam logic [7:0] ADDR_A1SEC = 8'h07; // First alarm seconds.
  localparam logic [7:0] ADDR_A1MIN = 8'h08; // First alarm minutes.
  localparam logic [7:0] ADDR_A1HR  = 8'h09; // First alarm hours.
  localparam logic [7:0] ADDR_A1DD  = 8'h0A; // First alarm day/date.
  localparam logic [7:0] ADDR_A2MIN = 8'h0B; // Second alarm minutes.
  localparam logic [7:0] ADDR_A2HR  = 8'h0C; // Second alarm hours.
  localparam logic [7:0] ADDR_A2DD  = 8'h0D; // Second alarm day/date.
  localparam logic [7:0] ADDR_CTRL  = 8'h0E; // Control.
  localparam logic [7:0] ADDR_STAT  = 8'h0F; // Status.
  localparam logic [7:0] ADDR_LAST  = 8'h0F; // Pointer wraps after this.
  localparam int         NUM_REGS   = 16;    // Storage slots.

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MASK_BIT      = 7; // Alarm field mask bit.
  localparam int DAY_SEL_BIT   = 6; // Day/date selector bit.
  localparam int A1_IE_BIT     = 0; // Control: first alarm enable.
  localparam int A2_IE_BIT     = 1; // Control: second alarm enable.
  localparam int ROUTE_BIT     = 2; // Control: output routing.
  localparam int A1_FLAG_BIT   = 0; // Status: first alarm flag.
  localparam int A2_FLAG_BIT   = 1; // Status: second alarm flag.
  localparam int OSC_FLAG_BIT  = 7; // Status: oscillator stopped.

  // ****************************************************************
  // Writable bits per register; the rest read as zero
  // ****************************************************************
  localparam logic [7:0] WMASK_TIME  = 8'h7F; // Seconds to hours.
  localparam logic [7:0] WMASK_WDAY  = 8'h07; // Weekday.
  localparam logic [7:0] WMASK_DATE  = 8'h3F; // Date.
  localparam logic [7:0] WMASK_ALARM = 8'hFF; // Alarm registers.
  localparam logic [7:0] WMASK_CTRL  = 8'h9F; // Control.

  // ****************************************************************
  // Reset values and serial port constants
  // ****************************************************************
  localparam logic [7:0] REG_RST    = 8'h00; // Every stored byte.
  localparam logic [6:0] SLAVE_ADDR = 7'h68; // Seven-bit bus address.
  localparam logic [3:0] BITS_BYTE  = 4'h8;  // Bits per byte.

  // Serial slave states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_MACK
  } slave_state_t;

endpackage : alarm_pkg

// File: alarm_if.sv
// Interface: alarm settings and current time handed to one comparator.
interface alarm_if;
  logic [7:0] al_sec;  // Alarm seconds, mask in bit 7.
  logic [7:0] al_min;  // Alarm minutes, mask in bit 7.
  logic [7:0] al_hour; // Alarm hours, mask in bit 7.
  logic [7:0] al_dd;   // Alarm day/date, mask and selector.
  logic [7:0] t_sec;   // Current seconds.
  logic [7:0] t_min;   // Current minutes.
  logic [7:0] t_hour;  // Current hours.
  logic [7:0] t_wday;  // Current weekday.
  logic [7:0] t_date;  // Current date.
  logic       match;   // Settings match the time.

  // Comparator side.
  modport cmp (input al_sec, al_min, al_hour, al_dd,
               input t_sec, t_min, t_hour, t_wday, t_date,
               output match);
  // Register file side.
  modport owner (output al_sec, al_min, al_hour, al_dd,
                 output t_sec, t_min, t_hour, t_wday, t_date,
                 input match);
endinterface : alarm_if

// File: alarm_compare.sv
// Module: one alarm comparator with mask-selected repeat rate.
module alarm_compare
  import alarm_pkg::*;
#(
  parameter bit HAS_SECONDS = 1'b1 // Alarm owns a seconds field.
)(
  alarm_if.cmp port
);

  // ****************************************************************
  // Field equality
  // ****************************************************************
  logic       sec_eq;  // Seconds agree.
  logic       min_eq;  // Minutes agree.
  logic       hour_eq; // Hours agree, format bits included.
  logic       dd_eq;   // Weekday or date agrees.
  logic       sec_zero; // Seconds count stands at zero.
  logic [3:0] masks;   // Day, hours, minutes, seconds masks.

  // The masks form a pattern; an alarm without seconds acts as if
  // its seconds mask were set.
  always_comb
  begin
    masks    = {port.al_dd[MASK_BIT], port.al_hour[MASK_BIT],
                port.al_min[MASK_BIT],
                HAS_SECONDS ? port.al_sec[MASK_BIT] : 1'b1};
    sec_eq   = port.al_sec[6:0] == port.t_sec[6:0];
    min_eq   = port.al_min[6:0] == port.t_min[6:0];
    hour_eq  = port.al_hour[6:0] == port.t_hour[6:0];
    sec_zero = port.t_sec[6:0] == 7'h00;
    // Selector set compares weekday, clear compares date.
    dd_eq    = port.al_dd[DAY_SEL_BIT] ?
               (port.al_dd[5:0] == port.t_wday[5:0]) :
               (port.al_dd[5:0] == port.t_date[5:0]);
  end

  // ****************************************************************
  // Rate decode
  // ****************************************************************
  // Only the listed patterns can match; any other one stays silent.
  always_comb
  begin
    case (masks)
      4'b1111: port.match = HAS_SECONDS ? 1'b1 : sec_zero;
      4'b1110: port.match = HAS_SECONDS & sec_eq;
      4'b1100: port.match = HAS_SECONDS & sec_eq & min_eq;
      4'b1000: port.match = HAS_SECONDS & sec_eq & min_eq & hour_eq;
      4'b0000: port.match = HAS_SECONDS & sec_eq & min_eq & hour_eq
                            & dd_eq;
      4'b1101: port.match = !HAS_SECONDS & min_eq;
      4'b1001: port.match = !HAS_SECONDS & min_eq & hour_eq;
      4'b0001: port.match = !HAS_SECONDS & min_eq & hour_eq
                            & dd_eq;
      default: port.match = 1'b0;
    endcase
  end

endmodule : alarm_compare

// File: dual_alarm_match_unit.sv
// Module: two-alarm match unit behind a two-wire serial slave port.
//
// Contract
// - Bit 7 masks its alarm field.
// - No masks: match all time registers.
// - Selector picks date or weekday compare.
// - Match sets the alarm's status flag.
// - Enabled set flag drives an interrupt pin.
// - Compare only at once-per-second update.
// - Control bit chooses interrupt output arrangement.
// - First alarm all masks: every second.
// - First alarm: seconds match.
// - First alarm: minutes and seconds match.
// - First alarm: hours, minutes, seconds match.
// - First alarm: full match with day/date.
// - Second alarm all masks: at seconds 00.
// - Second alarm: minutes match.
// - Second alarm: hours and minutes match.
// - Second alarm: full match with day/date.
// - Idle lines stay high, released.
// - Start/stop are data edges, clock high.
// - Data changes at clock low, sampled high.
// - Answer only to own slave address.
// - Writing zero clears flag, one keeps.
// - Routing bit picks dedicated or shared pin.
module dual_alarm_match_unit
  import alarm_pkg::*;
(
  input  wire logic clk_sys_i,      // System clock, 125 MHz.
  input  wire logic rst_i,          // Asynchronous reset, high.
  input  wire logic scl_i,          // Serial clock pin level.
  input  wire logic sda_i,          // Serial data pin level.
  output logic      sda_o,          // Serial data drive value.
  output logic      sda_oe_o,       // Serial data pulled low.
  input  wire logic second_tick_i,  // Once-per-second update.
  output logic      dedicated_irq_pin_n_o,       // Dedicated irq.
  output logic      square_or_shared_irq_pin_n_o // Shared irq.
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] scl_sync_q; // Three-stage chain for the clock pin.
  logic [2:0] sda_sync_q; // Three-stage chain for the data pin.
  logic       scl_q;      // Filtered clock level.
  logic       sda_q;      // Filtered data level.
  logic       scl_prev_q; // Filtered clock one cycle back.
  logic       sda_prev_q; // Filtered data one cycle back.

  // The pins start high, as an idle bus does.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
    end
  end

  // A level counts only once the second and third stages agree,
  // which also rejects single-cycle glitches on the bus.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      if (scl_sync_q[1] == scl_sync_q[2])
      begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2])
      begin
        sda_q <= sda_sync_q[2];
      end
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  // ****************************************************************
  // Bus events
  // ****************************************************************
  logic scl_rise;  // Clock went high: receiver samples here.
  logic scl_fall;  // Clock went low: transmitter changes here.
  logic bus_start; // Data fell while clock high.
  logic bus_stop;  // Data rose while clock high.

  // Both edges of the data line are judged against a steady clock.
  always_comb
  begin
    scl_rise  = scl_q & !scl_prev_q;
    scl_fall  = !scl_q & scl_prev_q;
    bus_start = scl_q & scl_prev_q & sda_prev_q & !sda_q;
    bus_stop  = scl_q & scl_prev_q & !sda_prev_q & sda_q;
  end

  // ****************************************************************
  // Register storage and read decode
  // ****************************************************************
  logic [7:0] regs_q [NUM_REGS]; // Time, alarm and control bytes.
  logic       a1_flag_q;        // First alarm flag.
  logic       a2_flag_q;        // Second alarm flag.
  logic       osc_flag_q;       // Oscillator stopped flag.
  logic [7:0] ptr_q;            // Register pointer.
  logic [7:0] rd_data;          // Byte at the pointer.
  logic [7:0] shift_q;          // Receive shift register.
  logic       wr_stb;           // Host writes a data byte now.

  // Writable bits of each slot; months and years are not kept here
  // and read as zero, as do the unused high bits.
  function automatic logic [7:0] wmask(input logic [7:0] idx);
    case (idx)
      ADDR_SEC, ADDR_MIN, ADDR_HOUR: wmask = WMASK_TIME;
      ADDR_WDAY:  wmask = WMASK_WDAY;
      ADDR_DATE:  wmask = WMASK_DATE;
      ADDR_A1SEC, ADDR_A1MIN, ADDR_A1HR, ADDR_A1DD,
      ADDR_A2MIN, ADDR_A2HR, ADDR_A2DD: wmask = WMASK_ALARM;
      ADDR_CTRL:  wmask = WMASK_CTRL;
      default:    wmask = 8'h00;
    endcase
  endfunction : wmask

  // Status is assembled from the live flags; every other slot reads
  // back its stored byte.
  always_comb
  begin
    if (ptr_q == ADDR_STAT)
    begin
      rd_data                = 8'h00;
      rd_data[OSC_FLAG_BIT]  = osc_flag_q;
      rd_data[A2_FLAG_BIT]   = a2_flag_q;
      rd_data[A1_FLAG_BIT]   = a1_flag_q;
    end
    else
    begin
      rd_data = regs_q[ptr_q[3:0]];
    end
  end

  // One write port for all slots; the mask keeps reserved bits at zero.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_q[i] <= REG_RST;
      end
    end
    else if (wr_stb)
    begin
      regs_q[ptr_q[3:0]] <= shift_q & wmask(ptr_q);
    end
  end

  // ****************************************************************
  // Alarm comparators
  // ****************************************************************
  alarm_if al_first ();  // First alarm, with seconds.
  alarm_if al_second (); // Second alarm, no seconds field.

  // The same current time feeds both comparators.
  assign al_first.t_sec   = regs_q[ADDR_SEC[3:0]];
  assign al_first.t_min   = regs_q[ADDR_MIN[3:0]];
  assign al_first.t_hour  = regs_q[ADDR_HOUR[3:0]];
  assign al_first.t_wday  = regs_q[ADDR_WDAY[3:0]];
  assign al_first.t_date  = regs_q[ADDR_DATE[3:0]];
  assign al_first.al_sec  = regs_q[ADDR_A1SEC[3:0]];
  assign al_first.al_min  = regs_q[ADDR_A1MIN[3:0]];
  assign al_first.al_hour = regs_q[ADDR_A1HR[3:0]];
  assign al_first.al_dd   = regs_q[ADDR_A1DD[3:0]];

  assign al_second.t_sec   = regs_q[ADDR_SEC[3:0]];
  assign al_second.t_min   = regs_q[ADDR_MIN[3:0]];
  assign al_second.t_hour  = regs_q[ADDR_HOUR[3:0]];
  assign al_second.t_wday  = regs_q[ADDR_WDAY[3:0]];
  assign al_second.t_date  = regs_q[ADDR_DATE[3:0]];
  assign al_second.al_sec  = 8'h80;
  assign al_second.al_min  = regs_q[ADDR_A2MIN[3:0]];
  assign al_second.al_hour = regs_q[ADDR_A2HR[3:0]];
  assign al_second.al_dd   = regs_q[ADDR_A2DD[3:0]];

  // First alarm comparator.
  alarm_compare #(
    .HAS_SECONDS (1'b1)
  ) u_first (
    .port (al_first.cmp)
  );

  // Second alarm comparator.
  alarm_compare #(
    .HAS_SECONDS (1'b0)
  ) u_second (
    .port (al_second.cmp)
  );

  // ****************************************************************
  // Alarm flags
  // ****************************************************************
  logic a1_set;   // First alarm matched at this update.
  logic a2_set;   // Second alarm matched at this update.
  logic stat_wr;  // Host writes the status byte now.

  // Matches only count on the update strobe, never in between, so a
  // host rewriting time fields cannot raise a stray flag.
  always_comb
  begin
    a1_set  = second_tick_i & al_first.match;
    a2_set  = second_tick_i & al_second.match;
    stat_wr = wr_stb && (ptr_q == ADDR_STAT);
  end

  // A set in the same cycle as a clearing write wins, so no match
  // is lost; writing one to a flag leaves it as it is.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      a1_flag_q  <= 1'b0;
      a2_flag_q  <= 1'b0;
      osc_flag_q <= 1'b0;
    end
    else
    begin
      if (a1_set)
      begin
        a1_flag_q <= 1'b1;
      end
      else if (stat_wr)
      begin
        a1_flag_q <= a1_flag_q & shift_q[A1_FLAG_BIT];
      end
      if (a2_set)
      begin
        a2_flag_q <= 1'b1;
      end
      else if (stat_wr)
      begin
        a2_flag_q <= a2_flag_q & shift_q[A2_FLAG_BIT];
      end
      if (stat_wr)
      begin
        osc_flag_q <= osc_flag_q & shift_q[OSC_FLAG_BIT];
      end
    end
  end

  // ****************************************************************
  // Interrupt outputs
  // ****************************************************************
  logic irq_active; // Some enabled flag is set.
  logic route_sel;  // Routing bit from the control byte.

  always_comb
  begin
    irq_active = (a1_flag_q & regs_q[ADDR_CTRL[3:0]][A1_IE_BIT]) |
                 (a2_flag_q & regs_q[ADDR_CTRL[3:0]][A2_IE_BIT]);
    route_sel  = regs_q[ADDR_CTRL[3:0]][ROUTE_BIT];
  end

  // Both alarms share whichever pin the routing bit names; the other
  // pin stays high since no square wave is produced here.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dedicated_irq_pin_n_o        <= 1'b1;
      square_or_shared_irq_pin_n_o <= 1'b1;
    end
    else
    begin
      dedicated_irq_pin_n_o        <= !(irq_active & !route_sel);
      square_or_shared_irq_pin_n_o <= !(irq_active & route_sel);
    end
  end

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  slave_state_t state_q;  // Slave state.
  slave_state_t next_q;   // State after the acknowledge bit.
  logic [3:0]   bcnt_q;   // Bits taken in the current byte.
  logic [7:0]   tx_q;     // Transmit shift register.
  logic         nack_q;   // Master declined the last byte.

  // A byte completes at the falling edge after its eighth bit.
  always_comb
  begin
    wr_stb = scl_fall && (state_q == ST_WDATA) && (bcnt_q == BITS_BYTE);
  end

  // The data pin is open drain: it is only ever pulled low.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sda_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
    end
  end

  // Protocol engine. Start and stop override every state, so a lost
  // master can always resynchronise the slave.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q  <= ST_IDLE;
      next_q   <= ST_IDLE;
      bcnt_q   <= 4'h0;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      nack_q   <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else if (bus_start)
    begin
      state_q  <= ST_ADDR;
      bcnt_q   <= 4'h0;
      sda_oe_o <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_q  <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end
    else if (scl_rise)
    begin
      // Receiver side samples while the clock is high.
      if (state_q == ST_MACK)
      begin
        nack_q <= sda_q;
      end
      else if (state_q != ST_IDLE && state_q != ST_ACK)
      begin
        shift_q <= {shift_q[6:0], sda_q};
        bcnt_q  <= bcnt_q + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      case (state_q)
        ST_ADDR:
        begin
          if (bcnt_q == BITS_BYTE)
          begin
            bcnt_q <= 4'h0;
            if (shift_q[7:1] == SLAVE_ADDR)
            begin
              sda_oe_o <= 1'b1;
              state_q  <= ST_ACK;
              next_q   <= shift_q[0] ? ST_RDATA : ST_PTR;
            end
            else
            begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_PTR:
        begin
          if (bcnt_q == BITS_BYTE)
          begin
            bcnt_q   <= 4'h0;
            ptr_q    <= shift_q;
            sda_oe_o <= 1'b1;
            state_q  <= ST_ACK;
            next_q   <= ST_WDATA;
          end
        end
        ST_WDATA:
        begin
          if (bcnt_q == BITS_BYTE)
          begin
            bcnt_q   <= 4'h0;
            ptr_q    <= (ptr_q == ADDR_LAST) ? 8'h00 : ptr_q + 8'h01;
            sda_oe_o <= 1'b1;
            state_q  <= ST_ACK;
            next_q   <= ST_WDATA;
          end
        end
        ST_ACK, ST_MACK:
        begin
          // Release after the acknowledge; on a read, the next byte
          // goes out unless the master said no.
          if (next_q == ST_RDATA && !(state_q == ST_MACK && nack_q))
          begin
            tx_q     <= {rd_data[6:0], 1'b0};
            sda_oe_o <= !rd_data[7];
            ptr_q    <= (ptr_q == ADDR_LAST) ? 8'h00 : ptr_q + 8'h01;
            bcnt_q   <= 4'h0;
            state_q  <= ST_RDATA;
          end
          else
          begin
            sda_oe_o <= 1'b0;
            state_q  <= (state_q == ST_MACK) ? ST_IDLE : next_q;
          end
        end
        ST_RDATA:
        begin
          if (bcnt_q == BITS_BYTE)
          begin
            sda_oe_o <= 1'b0;
            bcnt_q   <= 4'h0;
            state_q  <= ST_MACK;
          end
          else
          begin
            sda_oe_o <= !tx_q[7];
            tx_q     <= {tx_q[6:0], 1'b0};
          end
        end
        ST_IDLE:
        begin
          sda_oe_o <= 1'b0;
        end
        default:
        begin
          state_q  <= ST_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

endmodule : dual_alarm_match_unit

// File: alarm_unit_sva.sv
// Checker: port-level properties of the dual alarm match unit.
module alarm_unit_sva
  import alarm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic second_tick_i,
  input wire logic dedicated_irq_pin_n_o,
  input wire logic square_or_shared_irq_pin_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [3:0] idle_q; // Cycles with the clock line high, saturating.
  // Frames never hold the clock high this long, so it means idle.
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      idle_q <= 4'h0;
    else if (!scl_i)
      idle_q <= 4'h0;
    else if (idle_q != 4'hF)
      idle_q <= idle_q + 4'h1;
  property p_irq_excl;
    !(!dedicated_irq_pin_n_o && !square_or_shared_irq_pin_n_o);
  endproperty
  a_irq_excl: assert property (p_irq_excl)
    else $error("both interrupt pins low");
  property p_ded_rise;
    $rose(dedicated_irq_pin_n_o) |-> $past(sda_oe_o);
  endproperty
  a_ded_rise: assert property (p_ded_rise)
    else $error("dedicated pin released without a write");
  property p_sh_rise;
    $rose(square_or_shared_irq_pin_n_o) |-> $past(sda_oe_o);
  endproperty
  a_sh_rise: assert property (p_sh_rise)
    else $error("shared pin released without a write");
  property p_ded_fall;
    $fell(dedicated_irq_pin_n_o) |-> $past(second_tick_i, 2) || $past(sda_oe_o);
  endproperty
  a_ded_fall: assert property (p_ded_fall)
    else $error("dedicated pin fell without tick or write");
  property p_sh_fall;
    $fell(square_or_shared_irq_pin_n_o)
      |-> $past(second_tick_i, 2) || $past(sda_oe_o);
  endproperty
  a_sh_fall: assert property (p_sh_fall)
    else $error("shared pin fell without tick or write");
  property p_scl_high;
    $rose(scl_i) |-> ##2 $stable(sda_oe_o)[*3];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("data drive changed while clock high");
  property p_idle;
    idle_q == 4'hF |-> !sda_oe_o && !sda_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("data line driven while bus idle");
  property p_rst_rel;
    $fell(rst_i) |-> dedicated_irq_pin_n_o && square_or_shared_irq_pin_n_o
      && !sda_oe_o;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("outputs not idle after reset");
  c_ded: cover property ($fell(dedicated_irq_pin_n_o));
  c_sh: cover property ($fell(square_or_shared_irq_pin_n_o));
  c_ack: cover property ($rose(sda_oe_o));
endmodule : alarm_unit_sva

// File: bus_host_model.sv
// Partner: two-wire bus host; the data line has a pull-up.
module bus_host_model (
  output logic      scl_o,     // Serial clock, high when idle.
  output logic      sda_low_o, // High while the host pulls data low.
  input  wire logic sda_i      // Resolved data line.
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both lines released at rest.
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // One 80 ns clock pulse; data moves only while the clock is low.
  // Steps are whole multiples of 8 ns, so every line change lands on a
  // falling system clock edge, never on the edge the synchroniser samples.
  task automatic bit_io(input logic b, output logic r);
    #16 sda_low_o = !b;
    #24 scl_o = 1'b1;
    #16 r = sda_i;
    #24 scl_o = 1'b0;
  endtask : bit_io
  // The long first wait lets a slave acknowledge end before the clock rises.
  task automatic start();
    #56 sda_low_o = 1'b0;
    #24 scl_o = 1'b1;
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask : start
  task automatic stop();
    #56 sda_low_o = 1'b1;
    #24 scl_o = 1'b1;
    #40 sda_low_o = 1'b0;
    #200;
  endtask : stop
  // One byte, most significant bit first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(m, a);
  endtask : xfer
endmodule : bus_host_model

// File: tb_top.sv
// Testbench: alarm registers and interrupt pins over the two-wire port.
module tb_top import alarm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i, rst_i, second_tick_i, scl, sda_low, sda_o, sda_oe_o;
  logic ded_n, sh_n, a, irq;
  logic [7:0] q;
  logic [79:0] c;
  wire sda = !((sda_oe_o && !sda_o) || sda_low); // Pull-up wire.
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Rows: seconds, first alarm, second alarm, control, expected status.
  logic [79:0] tbl [17] = '{
    80'h15_80808080_808000_01_01, 80'h15_15808080_808000_05_01,
    80'h15_16808080_808000_01_00, 80'h15_15308080_808000_01_01,
    80'h15_15300880_808000_05_01, 80'h15_15300821_808000_01_01,
    80'h15_15300843_808000_05_01, 80'h15_15300841_808000_01_00,
    80'h15_95300821_808000_01_00, 80'h15_80808080_808080_02_01,
    80'h00_16808080_808080_06_02, 80'h15_16808080_308080_02_02,
    80'h15_16808080_300880_06_02, 80'h15_16808080_300821_02_02,
    80'h15_16808080_300843_06_02, 80'h15_16808080_310880_02_00,
    80'h00_80808080_808080_03_03};
  dual_alarm_match_unit dual_alarm_match_unit_i (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .second_tick_i(second_tick_i),
    .dedicated_irq_pin_n_o(ded_n), .square_or_shared_irq_pin_n_o(sh_n));
  bus_host_model bus_host_model_i (.scl_o(scl), .sda_low_o(sda_low),
    .sda_i(sda));
  task automatic chk(input string n, input logic [7:0] e, s);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic send(input logic [7:0] d);
    bus_host_model_i.xfer(d, 1'b1, q, a);
    chk("ack", 8'h00, {7'h00, a});
  endtask : send
  task automatic wr(input logic [7:0] p, input int n, input logic [127:0] d);
    bus_host_model_i.start();
    send(8'hD0);
    send(p);
    for (int i = 0; i < n; i++)
      send(d[8*(n-1-i) +: 8]);
    bus_host_model_i.stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    wr(p, 0, 128'h0);
    bus_host_model_i.start();
    send(8'hD1);
    bus_host_model_i.xfer(8'hFF, 1'b1, q, a);
    bus_host_model_i.stop();
    chk("register", e, q);
  endtask : rd
  // Pins are registered, so give them a few cycles to settle.
  task automatic pins(input logic d, s);
    repeat (4) @(negedge clk_sys_i);
    chk("dedicated", {7'h00, d}, {7'h00, ded_n});
    chk("shared", {7'h00, s}, {7'h00, sh_n});
  endtask : pins
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    second_tick_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    pins(1'b1, 1'b1);
    rd(ADDR_STAT, 8'h00);
    rd(ADDR_CTRL, 8'h00);
    bus_host_model_i.start();
    bus_host_model_i.xfer(8'hD2, 1'b1, q, a);
    chk("nack", 8'h01, {7'h00, a});
    bus_host_model_i.stop();
    wr(8'h05, 1, 128'h5A);
    rd(8'h05, 8'h00);
    for (int i = 0; i < 17; i++)
    begin
      c = tbl[i];
      wr(ADDR_SEC, 16, {c[79:72], 48'h300803210000, c[71:8], 8'h00});
      pins(1'b1, 1'b1);
      @(negedge clk_sys_i) second_tick_i = 1'b1;
      @(negedge clk_sys_i) second_tick_i = 1'b0;
      irq = |(c[9:8] & c[1:0]);
      pins(!(irq && !c[10]), !(irq && c[10]));
      rd(ADDR_STAT, c[7:0]);
      pins(!(irq && !c[10]), !(irq && c[10]));
    end
    wr(ADDR_STAT, 1, 128'h02);
    pins(1'b0, 1'b1);
    rd(ADDR_STAT, 8'h02);
    wr(ADDR_STAT, 1, 128'h00);
    pins(1'b1, 1'b1);
    conclude();
  end
endmodule : tb_top
bind dual_alarm_match_unit alarm_unit_sva alarm_unit_sva_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .second_tick_i(second_tick_i),
  .dedicated_irq_pin_n_o(dedicated_irq_pin_n_o),
  .square_or_shared_irq_pin_n_o(square_or_shared_irq_pin_n_o));
